// *** verilog/sdp_datapath.sv ***
/*
  Serial port transmit and receive data path with one-deep buffers each way.
  Assumes control bits and pins are synchronous to mclk_i; the transfer clock
  pin is an input (external clock) and must run below a quarter of mclk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module sdp_datapath (
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 sys_rst_i,
  // Configuration
  input  wire sdp_pkg::sdp_fmt_t    fmt_i,
  input  wire sdp_pkg::sdp_clkcfg_t clkcfg_i,
  input  wire logic                 transmit_enable_bit_i,
  input  wire logic                 receive_enable_bit_i,
  input  wire logic                 transmit_ninth_bit_i,
  input  wire logic                 data_empty_irq_enable_i,
  input  wire logic                 transmit_complete_irq_enable_i,
  // CPU access
  input  wire logic                 data_wr_i,
  input  wire logic [7:0]           data_wdata_i,
  input  wire logic                 data_rd_i,
  input  wire logic                 txc_clear_i,
  input  wire logic                 txc_irq_ack_i,
  // CPU view
  output logic [7:0]                rx_data_o,
  output logic                      rx_ninth_o,
  output logic                      data_empty_flag_o,
  output logic                      transmit_complete_flag_o,
  output logic                      receive_complete_flag_o,
  output logic                      data_empty_irq_o,
  output logic                      transmit_complete_irq_o,
  // Line
  input  wire logic                 rxd_i,
  input  wire logic                 transfer_clock_pin_i,
  output logic                      txd_o,
  output logic                      txd_oe_o
);

  logic                   baud_tick;
  logic                   xck_change;
  logic                   xck_sample;
  logic [3:0]             nbits;
  logic [sdp_pkg::OVS_W-1:0] ovs;
  logic [sdp_pkg::OVS_W-1:0] ovs_half;

  sdp_baud #(
    .DIV_W (sdp_pkg::DIV_W)
  ) u_baud (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .div_i     (clkcfg_i.baud_div),
    .tick_o    (baud_tick)
  );

  sdp_edge u_edge (
    .mclk_i     (mclk_i),
    .sys_rst_i  (sys_rst_i),
    .pin_i      (transfer_clock_pin_i),
    .polarity_i (clkcfg_i.clk_polarity),
    .change_o   (xck_change),
    .sample_o   (xck_sample)
  );

  assign nbits    = sdp_pkg::sdp_nbits(fmt_i.size_code);
  assign ovs      = clkcfg_i.double_speed ? sdp_pkg::OVS_DOUBLE : sdp_pkg::OVS_NORMAL;
  assign ovs_half = ovs >> 1;

  // Transmit side
  sdp_pkg::sdp_tx_state_t    tx_state_reg;
  logic [8:0]                txbuf_reg;
  logic [8:0]                txsh_reg;
  logic [3:0]                tx_bit_reg;
  logic [sdp_pkg::OVS_W-1:0] tx_ovs_reg;
  logic                      tx_par_reg;
  logic                      tx_step;
  logic                      tx_frame_end;
  logic                      tx_load;
  logic                      tx_line;
  logic [8:0]                wr_masked;

  // Short characters drop the unused upper bits here
  always_comb begin
    wr_masked = {transmit_ninth_bit_i, data_wdata_i} & ~(9'h1FF << nbits);
  end

  // Bit boundary: external clock edge or oversampled divider
  assign tx_step = clkcfg_i.sync_mode ? xck_change
                 : (baud_tick && tx_ovs_reg == ovs - 1'b1);
  assign tx_frame_end = tx_step && ((tx_state_reg == sdp_pkg::TX_STOP1 && !fmt_i.stop_two)
                                 || tx_state_reg == sdp_pkg::TX_STOP2);
  assign tx_load = !data_empty_flag_o
                && (tx_state_reg == sdp_pkg::TX_IDLE || tx_frame_end);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || tx_state_reg == sdp_pkg::TX_IDLE) begin
      tx_ovs_reg <= '0;
    end else if (baud_tick) begin
      tx_ovs_reg <= (tx_ovs_reg == ovs - 1'b1) ? '0 : tx_ovs_reg + 1'b1;
    end
  end

  // Transmit buffer; a write while full overwrites the waiting character
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      txbuf_reg         <= '0;
      data_empty_flag_o <= 1'b1;
    end else if (data_wr_i && transmit_enable_bit_i) begin
      txbuf_reg         <= wr_masked;
      data_empty_flag_o <= 1'b0;
    end else if (tx_load) begin
      data_empty_flag_o <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      tx_state_reg <= sdp_pkg::TX_IDLE;
      txsh_reg     <= '0;
      tx_bit_reg   <= '0;
      tx_par_reg   <= 1'b0;
    end else if (tx_load) begin
      tx_state_reg <= sdp_pkg::TX_START;
      txsh_reg     <= txbuf_reg;
      tx_bit_reg   <= '0;
      tx_par_reg   <= (^txbuf_reg) ^ fmt_i.parity_odd;
    end else if (tx_step) begin
      unique case (tx_state_reg)
        sdp_pkg::TX_IDLE:  tx_state_reg <= sdp_pkg::TX_IDLE;
        sdp_pkg::TX_START: tx_state_reg <= sdp_pkg::TX_DATA;
        sdp_pkg::TX_DATA: begin
          if (tx_bit_reg == nbits - 1'b1) begin
            tx_state_reg <= fmt_i.parity_en ? sdp_pkg::TX_PARITY : sdp_pkg::TX_STOP1;
          end else begin
            tx_bit_reg <= tx_bit_reg + 1'b1;
          end
        end
        sdp_pkg::TX_PARITY: tx_state_reg <= sdp_pkg::TX_STOP1;
        sdp_pkg::TX_STOP1: begin
          tx_state_reg <= fmt_i.stop_two ? sdp_pkg::TX_STOP2 : sdp_pkg::TX_IDLE;
        end
        sdp_pkg::TX_STOP2: tx_state_reg <= sdp_pkg::TX_IDLE;
      endcase
    end
  end

  always_comb begin
    unique case (tx_state_reg)
      sdp_pkg::TX_START:  tx_line = sdp_pkg::LINE_START;
      sdp_pkg::TX_DATA:   tx_line = txsh_reg[tx_bit_reg];
      sdp_pkg::TX_PARITY: tx_line = tx_par_reg;
      sdp_pkg::TX_STOP1:  tx_line = sdp_pkg::LINE_STOP;
      sdp_pkg::TX_STOP2:  tx_line = sdp_pkg::LINE_STOP;
      default:            tx_line = sdp_pkg::LINE_IDLE;
    endcase
  end

  // Pin stays ours until enable is off and nothing is left to send
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      txd_o    <= sdp_pkg::LINE_IDLE;
      txd_oe_o <= 1'b0;
    end else begin
      txd_o    <= tx_line;
      txd_oe_o <= transmit_enable_bit_i || !data_empty_flag_o
               || tx_state_reg != sdp_pkg::TX_IDLE;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      transmit_complete_flag_o <= 1'b0;
    end else if (tx_frame_end && data_empty_flag_o) begin
      transmit_complete_flag_o <= 1'b1;
    end else if (txc_clear_i || txc_irq_ack_i) begin
      transmit_complete_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      data_empty_irq_o        <= 1'b0;
      transmit_complete_irq_o <= 1'b0;
    end else begin
      data_empty_irq_o        <= data_empty_irq_enable_i && data_empty_flag_o;
      transmit_complete_irq_o <= transmit_complete_irq_enable_i
                              && transmit_complete_flag_o
                              && !(txc_clear_i || txc_irq_ack_i);
    end
  end

  // Receive side
  sdp_pkg::sdp_rx_state_t    rx_state_reg;
  logic [8:0]                rxsh_reg;
  logic [3:0]                rx_bit_reg;
  logic [sdp_pkg::OVS_W-1:0] rx_ovs_reg;
  logic                      rx_sample;
  logic                      rx_start_seen;
  logic                      rx_done;

  // Mid-bit sample: half a bit into the start, a full bit after that
  always_comb begin
    if (clkcfg_i.sync_mode) begin
      rx_sample = xck_sample;
    end else begin
      rx_sample = baud_tick && rx_ovs_reg == ((rx_state_reg == sdp_pkg::RX_START)
                  ? ovs_half - 1'b1 : ovs - 1'b1);
    end
  end

  assign rx_start_seen = receive_enable_bit_i && rxd_i == sdp_pkg::LINE_START
                      && (!clkcfg_i.sync_mode || xck_sample);
  assign rx_done = rx_sample && rx_state_reg == sdp_pkg::RX_STOP;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || rx_state_reg == sdp_pkg::RX_IDLE) begin
      rx_ovs_reg <= '0;
    end else if (baud_tick) begin
      rx_ovs_reg <= rx_sample ? '0 : rx_ovs_reg + 1'b1;
    end
  end

  // Disabling stops reception at once; a partial frame is lost
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !receive_enable_bit_i) begin
      rx_state_reg <= sdp_pkg::RX_IDLE;
      rxsh_reg     <= '0;
      rx_bit_reg   <= '0;
    end else begin
      unique case (rx_state_reg)
        sdp_pkg::RX_IDLE: begin
          if (rx_start_seen) begin
            rx_state_reg <= clkcfg_i.sync_mode ? sdp_pkg::RX_DATA : sdp_pkg::RX_START;
            rxsh_reg     <= '0;
            rx_bit_reg   <= '0;
          end
        end
        sdp_pkg::RX_START: begin
          if (rx_sample) begin
            // A glitch that is high again at mid-bit is no start bit
            rx_state_reg <= (rxd_i == sdp_pkg::LINE_START) ? sdp_pkg::RX_DATA
                                                           : sdp_pkg::RX_IDLE;
          end
        end
        sdp_pkg::RX_DATA: begin
          if (rx_sample) begin
            rxsh_reg[rx_bit_reg] <= rxd_i;
            if (rx_bit_reg == nbits - 1'b1) begin
              rx_state_reg <= fmt_i.parity_en ? sdp_pkg::RX_PARITY : sdp_pkg::RX_STOP;
            end else begin
              rx_bit_reg <= rx_bit_reg + 1'b1;
            end
          end
        end
        sdp_pkg::RX_PARITY: begin
          if (rx_sample) begin
            rx_state_reg <= sdp_pkg::RX_STOP;
          end
        end
        sdp_pkg::RX_STOP: begin
          if (rx_sample) begin
            rx_state_reg <= sdp_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  // Receive buffer; a new frame wins over a read in the same cycle
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rx_data_o  <= '0;
      rx_ninth_o <= 1'b0;
    end else if (rx_done) begin
      rx_data_o  <= rxsh_reg[7:0];
      rx_ninth_o <= rxsh_reg[8];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !receive_enable_bit_i) begin
      receive_complete_flag_o <= 1'b0;
    end else if (rx_done) begin
      receive_complete_flag_o <= 1'b1;
    end else if (data_rd_i) begin
      receive_complete_flag_o <= 1'b0;
    end
  end

endmodule : sdp_datapath
`default_nettype wire

// *** shared/sdp_pkg.sv ***
/*
  Constants, types and helpers for the serial port transmit/receive data path.
  Assumes one system clock; all pins and control bits are synchronous to it.
*/
package sdp_pkg;

  localparam int DIV_W = 12;
  localparam int OVS_W = 5;

  localparam logic [OVS_W-1:0] OVS_NORMAL = 5'h10;
  localparam logic [OVS_W-1:0] OVS_DOUBLE = 5'h08;

  localparam logic [2:0] SIZE_5 = 3'h0;
  localparam logic [2:0] SIZE_6 = 3'h1;
  localparam logic [2:0] SIZE_7 = 3'h2;
  localparam logic [2:0] SIZE_9 = 3'h7;

  localparam logic [3:0] BITS_5 = 4'h5;
  localparam logic [3:0] BITS_6 = 4'h6;
  localparam logic [3:0] BITS_7 = 4'h7;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;

  localparam logic LINE_IDLE = 1'b1;
  localparam logic LINE_START = 1'b0;
  localparam logic LINE_STOP = 1'b1;

  typedef struct packed {
    logic [2:0] size_code;
    logic       parity_en;
    logic       parity_odd;
    logic       stop_two;
  } sdp_fmt_t;

  typedef struct packed {
    logic             sync_mode;
    logic             clk_polarity;
    logic             double_speed;
    logic [DIV_W-1:0] baud_div;
  } sdp_clkcfg_t;

  typedef enum logic [5:0] {
    TX_IDLE   = 6'h01,
    TX_START  = 6'h02,
    TX_DATA   = 6'h04,
    TX_PARITY = 6'h08,
    TX_STOP1  = 6'h10,
    TX_STOP2  = 6'h20
  } sdp_tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE   = 5'h01,
    RX_START  = 5'h02,
    RX_DATA   = 5'h04,
    RX_PARITY = 5'h08,
    RX_STOP   = 5'h10
  } sdp_rx_state_t;

  function automatic logic [3:0] sdp_nbits(input logic [2:0] code);
    unique case (code)
      SIZE_5:  sdp_nbits = BITS_5;
      SIZE_6:  sdp_nbits = BITS_6;
      SIZE_7:  sdp_nbits = BITS_7;
      SIZE_9:  sdp_nbits = BITS_9;
      default: sdp_nbits = BITS_8;
    endcase
  endfunction : sdp_nbits

endpackage : sdp_pkg

// *** verilog/sdp_baud.sv ***
/*
  Baud divider: one-cycle tick every (div + 1) system clocks.
  Assumes div is held steady while frames are in flight.
*/
`timescale 1ns/1ps
`default_nettype none
module sdp_baud #(
  parameter int DIV_W = sdp_pkg::DIV_W
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             sys_rst_i,
  // Divider
  input  wire logic [DIV_W-1:0] div_i,
  output logic                  tick_o
);

  logic [DIV_W-1:0] cnt_reg;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cnt_reg <= '0;
      tick_o  <= 1'b0;
    end else if (cnt_reg == '0) begin
      cnt_reg <= div_i;
      tick_o  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg - 1'b1;
      tick_o  <= 1'b0;
    end
  end

endmodule : sdp_baud
`default_nettype wire

// *** verilog/sdp_edge.sv ***
/*
  Transfer clock edge finder: change and sample strobes per polarity.
  Assumes the pin is already synchronous to the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sdp_edge (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  // Pin and polarity
  input  wire logic pin_i,
  input  wire logic polarity_i,
  // Strobes
  output logic      change_o,
  output logic      sample_o
);

  logic last_reg;
  logic rise;
  logic fall;

  assign rise = pin_i & ~last_reg;
  assign fall = ~pin_i & last_reg;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      last_reg <= 1'b0;
      change_o <= 1'b0;
      sample_o <= 1'b0;
    end else begin
      last_reg <= pin_i;
      // Polarity zero: data changes on rise, sampled on fall
      change_o <= polarity_i ? fall : rise;
      sample_o <= polarity_i ? rise : fall;
    end
  end

endmodule : sdp_edge
`default_nettype wire

// *** tb/sdp_line_model.sv ***
/*
  Far-side line model: remote sender on rxd and mid-bit sampler of txd.
  Assumes asynchronous framing at bit_clks system clocks per bit.
*/
`timescale 1ns/1ps
`default_nettype none
module sdp_line_model (
  // Clock and line
  input  wire logic mclk_i,
  input  wire logic txd_i,
  input  wire logic txd_oe_i,
  output logic      rxd_o
);
  int   bit_clks = 32;
  logic line;
  // Released pin reads high through the pull-up
  assign line = txd_oe_i ? txd_i : 1'b1;
  initial rxd_o = 1'b1;
  task automatic send(input logic [12:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rxd_o = bits[i];
      repeat (bit_clks) @(negedge mclk_i);
    end
    rxd_o = 1'b1;
  endtask : send
  // Stops at mid last bit so a following frame is not missed
  task automatic grab(input int n, output logic [12:0] bits, output logic ok);
    int k;
    bits = '0;
    k = 0;
    while (line !== 1'b0 && k < 4000) begin
      @(negedge mclk_i);
      k++;
    end
    ok = (k < 4000);
    repeat (bit_clks / 2) @(negedge mclk_i);
    for (int i = 0; i < n; i++) begin
      bits[i] = line;
      if (i < n - 1) repeat (bit_clks) @(negedge mclk_i);
    end
  endtask : grab
endmodule : sdp_line_model
`default_nettype wire

// *** tb/sdp_datapath_assertions.sv ***
/*
  Port checker for the serial data path.
  Assumes one clock domain; bound into every data path instance.
*/
`timescale 1ns/1ps
`default_nettype none
module sdp_datapath_assertions (
  // Clock and control
  input wire logic                 mclk_i,
  input wire logic                 sys_rst_i,
  input wire sdp_pkg::sdp_fmt_t    fmt_i,
  input wire sdp_pkg::sdp_clkcfg_t clkcfg_i,
  input wire logic                 transmit_enable_bit_i,
  input wire logic                 receive_enable_bit_i,
  input wire logic                 data_empty_irq_enable_i,
  input wire logic                 transmit_complete_irq_enable_i,
  input wire logic                 data_wr_i,
  input wire logic                 txc_clear_i,
  input wire logic                 txc_irq_ack_i,
  // Observed outputs
  input wire logic [7:0]           rx_data_o,
  input wire logic                 rx_ninth_o,
  input wire logic                 data_empty_flag_o,
  input wire logic                 transmit_complete_flag_o,
  input wire logic                 receive_complete_flag_o,
  input wire logic                 data_empty_irq_o,
  input wire logic                 transmit_complete_irq_o,
  input wire logic                 txd_o,
  input wire logic                 txd_oe_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  a_write_clears_empty: assert property (data_wr_i && transmit_enable_bit_i |=> !data_empty_flag_o)
    else $error("empty flag stayed high after a write");
  a_empty_irq_level: assert property (!$past(sys_rst_i) |->
    data_empty_irq_o == $past(data_empty_irq_enable_i && data_empty_flag_o))
    else $error("empty interrupt does not follow flag");
  a_txc_irq_level: assert property (!$past(sys_rst_i) |-> transmit_complete_irq_o ==
    $past(transmit_complete_irq_enable_i && transmit_complete_flag_o && !txc_clear_i && !txc_irq_ack_i))
    else $error("complete interrupt does not follow flag");
  a_txc_clear_works: assert property ((txc_clear_i || txc_irq_ack_i) && transmit_complete_flag_o
    |=> !transmit_complete_flag_o)
    else $error("complete flag not cleared");
  a_txc_when_idle: assert property ($rose(transmit_complete_flag_o) |-> data_empty_flag_o && txd_o)
    else $error("complete flag set with data pending");
  a_release_drained: assert property ($fell(txd_oe_o) |-> data_empty_flag_o && !transmit_enable_bit_i)
    else $error("pin released before drain");
  a_bit_min_hold: assert property (!clkcfg_i.sync_mode && txd_oe_o && $changed(txd_o)
    |=> $stable(txd_o) [*7])
    else $error("serial bit shorter than one bit time");
  a_rx_high_zero: assert property (receive_complete_flag_o |->
    (fmt_i.size_code == sdp_pkg::SIZE_9 || !rx_ninth_o) &&
    (fmt_i.size_code != sdp_pkg::SIZE_5 || rx_data_o[7:5] == 3'h0))
    else $error("unused received bits not zero");
  a_rx_flush: assert property (!receive_enable_bit_i |=> !receive_complete_flag_o)
    else $error("receive flag kept while disabled");
endmodule : sdp_datapath_assertions
bind sdp_datapath sdp_datapath_assertions chk (.*);
`default_nettype wire

// *** tb/sdp_datapath_test.sv ***
/*
  Self-checking bench for the serial data path, random formats, fixed seed.
  Assumes baud_div 1: 32 or 16 clocks per bit in asynchronous mode, then one
  synchronous frame each way on a 16-clock transfer clock, polarity zero.
*/
`timescale 1ns/1ps
`default_nettype none
module sdp_datapath_test;
  logic mclk_i = 1'b0, sys_rst_i = 1'b1, txe = 1'b0, rxe = 1'b0, ninth = 1'b0;
  logic dei = 1'b0, tci = 1'b0, wr = 1'b0, rd = 1'b0, tclr = 1'b0, tack = 1'b0;
  logic transfer_clock_pin = 1'b0, rxd, rx_ninth, empty, transmit_complete_flag, receive_complete_flag, de_irq, tc_irq, txd, txd_oe, ok;
  logic [7:0] wdata = 8'h00, rx_data;
  logic [8:0] d, e;
  logic [12:0] got, got2;
  logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  sdp_pkg::sdp_fmt_t fmt = '0;
  sdp_pkg::sdp_clkcfg_t ccfg = '{1'b0, 1'b0, 1'b0, 12'h001};
  int bad_count = 0;
  int samples_checked = 0;
  always #12.5 mclk_i = ~mclk_i;
  sdp_datapath dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .fmt_i(fmt), .clkcfg_i(ccfg),
    .transmit_enable_bit_i(txe), .receive_enable_bit_i(rxe), .transmit_ninth_bit_i(ninth),
    .data_empty_irq_enable_i(dei), .transmit_complete_irq_enable_i(tci), .data_wr_i(wr),
    .data_wdata_i(wdata), .data_rd_i(rd), .txc_clear_i(tclr), .txc_irq_ack_i(tack),
    .rx_data_o(rx_data), .rx_ninth_o(rx_ninth), .data_empty_flag_o(empty),
    .transmit_complete_flag_o(transmit_complete_flag), .receive_complete_flag_o(receive_complete_flag), .data_empty_irq_o(de_irq),
    .transmit_complete_irq_o(tc_irq), .rxd_i(rxd), .transfer_clock_pin_i(transfer_clock_pin), .txd_o(txd),
    .txd_oe_o(txd_oe));
  sdp_line_model far (.mclk_i(mclk_i), .txd_i(txd), .txd_oe_i(txd_oe), .rxd_o(rxd));
  task automatic check_bit(input logic got_v, input logic exp_v);
    samples_checked++;
    if (got_v !== exp_v) begin
      bad_count++;
      $display("ERROR %0t flag %b expected %b", $time, got_v, exp_v);
    end
  endtask : check_bit
  task automatic check_vec(input logic [12:0] got_v, input logic [12:0] exp_v);
    samples_checked++;
    if (got_v !== exp_v) begin
      bad_count++;
      $display("ERROR %0t bits %h expected %h", $time, got_v, exp_v);
    end
  endtask : check_vec
  function automatic int nbits(input logic [2:0] c);
    return (c < 3'h3) ? int'(c) + 5 : (c == 3'h7) ? 9 : 8;
  endfunction : nbits
  function automatic int flen(input sdp_pkg::sdp_fmt_t f);
    return nbits(f.size_code) + 2 + int'(f.parity_en) + int'(f.stop_two);
  endfunction : flen
  function automatic logic [12:0] lmask(input int n);
    return (13'h0001 << n) - 13'h0001;
  endfunction : lmask
  // Start low, data LSB first, parity, then high stop bits
  function automatic logic [12:0] fbits(input sdp_pkg::sdp_fmt_t f, input logic [8:0] v);
    logic [12:0] m;
    int n;
    n = nbits(f.size_code);
    m = 13'(v) & lmask(n);
    fbits = ~(lmask(n) << 1) | (m << 1);
    fbits[0] = 1'b0;
    if (f.parity_en) fbits[n + 1] = ^m ^ f.parity_odd;
  endfunction : fbits
  task automatic write(input logic [8:0] v);
    @(negedge mclk_i);
    wr = 1'b1;
    wdata = v[7:0];
    ninth = v[8];
    @(negedge mclk_i);
    wr = 1'b0;
    wdata = 8'($urandom);
    ninth = 1'($urandom);
  endtask : write
  task automatic pulse(ref logic s);
    @(negedge mclk_i);
    s = 1'b1;
    @(negedge mclk_i);
    s = 1'b0;
    @(negedge mclk_i);
  endtask : pulse
  task automatic wait_val(ref logic s, input logic v);
    int k;
    k = 0;
    while (s !== v && k < 2000) begin
      @(negedge mclk_i);
      k++;
    end
    check_bit(s, v);
  endtask : wait_val
  task automatic wrap_up();
    if (bad_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (60000) @(posedge mclk_i);
    bad_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h913AAFE7));
    repeat (20) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    @(negedge mclk_i);
    check_vec({txd, txd_oe, empty, transmit_complete_flag, receive_complete_flag, rx_data}, 13'h1400);
    write(9'h0A5);
    check_bit(empty, 1'b1);
    {txe, rxe, dei, tci} = 4'hF;
    @(negedge mclk_i);
    check_bit(de_irq, 1'b1);
    for (int r = 0; r < 10; r++) begin
      fmt = '{codes[r % 5], 1'($urandom), 1'($urandom), 1'($urandom)};
      ccfg.double_speed = r[1];
      far.bit_clks = r[1] ? 16 : 32;
      d = 9'($urandom);
      fork
        write(d);
        far.grab(flen(fmt), got, ok);
      join
      check_vec(got, fbits(fmt, d) & lmask(flen(fmt)));
      check_bit(ok, 1'b1);
      wait_val(transmit_complete_flag, 1'b1);
      // Interrupt is registered one cycle behind the flag
      @(negedge mclk_i);
      check_bit(tc_irq, 1'b1);
      if (r[0]) pulse(tclr);
      else pulse(tack);
      check_bit(transmit_complete_flag, 1'b0);
    end
    fmt = '{3'h3, 1'b0, 1'b0, 1'b1};
    d = 9'($urandom);
    e = 9'($urandom);
    fork
      begin
        write(d);
        wait_val(empty, 1'b1);
        write(e);
        check_bit(empty, 1'b0);
        txe = 1'b0;
        write(9'h03C);
      end
      begin
        far.grab(11, got, ok);
        far.grab(11, got2, ok);
      end
    join
    check_vec(got, fbits(fmt, d) & lmask(11));
    check_vec(got2, fbits(fmt, e) & lmask(11));
    wait_val(txd_oe, 1'b0);
    check_bit(empty, 1'b1);
    pulse(tclr);
    txe = 1'b1;
    for (int r = 0; r < 10; r++) begin
      fmt = '{codes[r % 5], 1'($urandom), 1'($urandom), 1'($urandom)};
      ccfg.double_speed = r[0];
      far.bit_clks = r[0] ? 16 : 32;
      d = 9'($urandom);
      far.send(fbits(fmt, d), flen(fmt));
      wait_val(receive_complete_flag, 1'b1);
      check_vec(13'({rx_ninth, rx_data}), 13'(d) & lmask(nbits(fmt.size_code)));
      pulse(rd);
      check_bit(receive_complete_flag, 1'b0);
    end
    fmt.stop_two = 1'b1;
    d = 9'($urandom);
    e = 9'($urandom);
    fork
      begin
        far.send(fbits(fmt, d), flen(fmt) - 1);
        far.send(fbits(fmt, e), flen(fmt));
      end
      begin
        wait_val(receive_complete_flag, 1'b1);
        check_vec(13'({rx_ninth, rx_data}), 13'(d) & lmask(nbits(fmt.size_code)));
        pulse(rd);
        wait_val(receive_complete_flag, 1'b1);
        check_vec(13'({rx_ninth, rx_data}), 13'(e) & lmask(nbits(fmt.size_code)));
      end
    join
    rxe = 1'b0;
    repeat (2) @(negedge mclk_i);
    check_bit(receive_complete_flag, 1'b0);
    dei = 1'b0;
    repeat (2) @(negedge mclk_i);
    check_bit(de_irq, 1'b0);
    // Synchronous slave: change on rise, sample on fall
    ccfg = '{1'b1, 1'b0, 1'b0, 12'h001};
    rxe = 1'b1;
    fmt = '{codes[$urandom % 5], 1'($urandom), 1'($urandom), 1'($urandom)};
    d = 9'($urandom);
    got = '0;
    write(d);
    for (int i = 0; i < flen(fmt); i++) begin
      repeat (8) @(negedge mclk_i);
      got[i] = txd;
      transfer_clock_pin = 1'b1;
      repeat (8) @(negedge mclk_i);
      transfer_clock_pin = 1'b0;
    end
    check_vec(got, fbits(fmt, d) & lmask(flen(fmt)));
    wait_val(transmit_complete_flag, 1'b1);
    pulse(tclr);
    far.bit_clks = 16;
    d = 9'($urandom);
    fork
      far.send(fbits(fmt, d), flen(fmt));
      for (int i = 0; i < flen(fmt); i++) begin
        transfer_clock_pin = 1'b1;
        repeat (8) @(negedge mclk_i);
        transfer_clock_pin = 1'b0;
        repeat (8) @(negedge mclk_i);
      end
    join
    wait_val(receive_complete_flag, 1'b1);
    check_vec(13'({rx_ninth, rx_data}), 13'(d) & lmask(nbits(fmt.size_code)));
    wrap_up();
  end
endmodule : sdp_datapath_test
`default_nettype wire
